// ---- src/tmr8_core.sv ----
// Eight-bit timer/counter with prescaler and AHB-Lite register slave
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tmr8_core
    import tmr8_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins and system
    input wire logic external_count_input,
    input wire logic sleep_mode,
    // Results
    output logic irq,
    output logic overflow_gate
);

    // ==========================================================
    // Declarations
    bus_req_t req_q;
    logic [31:0] rdata_q;
    logic [7:0] count_register_q;
    option_t opt_q;
    logic overflow_flag_q;
    logic overflow_irq_enable_q;
    logic [1:0] phase_q;
    logic ext_meta_q;
    logic ext_sync_q;
    logic src_prev_q;
    logic smp_q;
    logic smp_prev_q;
    logic resync_q;
    logic ovf_pulse_q;
    holdoff_t hold_q;
    logic run;
    logic q2_en;
    logic q4_en;
    logic icyc_level;
    logic src_level;
    logic src_edge;
    logic psc_tap;
    logic psc_out;
    logic inc;
    logic wrap;
    logic wr_commit;
    logic wr_count;
    logic wr_option;
    logic wr_intctl;
    logic wr_status;
    logic wr_mask;
    logic addr_phase;
    logic [31:0] rd_mux;
    logic [7:0] wofs;

    // ==========================================================
    // Bus decode
    assign addr_phase = hsel && hready && htrans[1];
    // Upper address bits must be zero, as on the read side, so no alias
    assign wr_commit = req_q.valid && req_q.write
        && (req_q.addr[31:8] == 24'h00_0000);
    assign wofs = req_q.addr[7:0];
    assign wr_count = wr_commit && (wofs == COUNT_OFS);
    assign wr_option = wr_commit && (wofs == OPTION_OFS);
    assign wr_intctl = wr_commit && (wofs == INTCTL_OFS);
    assign wr_status = wr_commit && (wofs == IRQ_STATUS_OFS);
    assign wr_mask = wr_commit && (wofs == IRQ_MASK_OFS);

    // Single-cycle slave: never stalls, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.valid <= addr_phase;
            req_q.write <= hwrite;
            req_q.addr <= haddr;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[31:0])
            {24'h00_0000, COUNT_OFS}: begin
                rd_mux[7:0] = count_register_q;
            end
            {24'h00_0000, OPTION_OFS}: begin
                rd_mux[OPT_SRC_BIT] = opt_q.src_sel;
                rd_mux[OPT_EDGE_BIT] = opt_q.edge_sel;
                rd_mux[OPT_BYP_BIT] = opt_q.bypass;
                rd_mux[OPT_RATE_LSB +: RATE_WIDTH] = opt_q.rate;
            end
            {24'h00_0000, INTCTL_OFS}: begin
                rd_mux[INT_EN_BIT] = overflow_irq_enable_q;
                rd_mux[INT_FLAG_BIT] = overflow_flag_q;
            end
            {24'h00_0000, IRQ_STATUS_OFS}: begin
                rd_mux[IRQ_OVF_BIT] = overflow_flag_q;
            end
            {24'h00_0000, IRQ_MASK_OFS}: begin
                rd_mux[IRQ_OVF_BIT] = overflow_irq_enable_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data sampled in the address phase, presented in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            rdata_q <= rd_mux;
        end
    end

    // ==========================================================
    // Instruction clock phases
    // Sleep freezes the phase counter, so nothing downstream moves
    assign run = !sleep_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= 2'h0;
        end else if (run) begin
            if (phase_q == PHASES_PER_CYCLE_M1) begin
                phase_q <= 2'h0;
            end else begin
                phase_q <= phase_q + 2'h1;
            end
        end
    end

    assign q2_en = run && (phase_q == PHASE_Q2);
    assign q4_en = run && (phase_q == PHASE_Q4);
    // High in the last half of each cycle: hclk divided by four
    assign icyc_level = phase_q[1];

    // ==========================================================
    // External pin synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
        end else begin
            ext_meta_q <= external_count_input;
            ext_sync_q <= ext_meta_q;
        end
    end

    // ==========================================================
    // Source select and edge polarity
    always_comb begin
        if (opt_q.src_sel) begin
            src_level = ext_sync_q ^ opt_q.edge_sel;
        end else begin
            src_level = icyc_level ^ opt_q.edge_sel;
        end
    end

    // After an option change one cycle of edges is dropped, so a
    // polarity or source flip cannot fake an increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Idle source level after reset: pin low, falling-edge select
            src_prev_q <= OPTION_RST[OPT_EDGE_BIT];
            resync_q <= 1'b0;
        end else begin
            src_prev_q <= src_level;
            resync_q <= wr_option;
        end
    end

    assign src_edge = run && src_level && !src_prev_q && !resync_q;

    // ==========================================================
    // Prescaler
    tmr8_prescaler #(
        .WIDTH(PSC_WIDTH),
        .SEL_WIDTH(RATE_WIDTH)
    ) u_psc (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(wr_count),
        .step(src_edge),
        .rate(opt_q.rate),
        .tap(psc_tap)
    );

    // Bypass routes the source level past the divider
    assign psc_out = opt_q.bypass ? src_level : psc_tap;

    // ==========================================================
    // Phase-two and phase-four sampling of the prescaler output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Match the bypassed idle level so release is not a rise
            smp_q <= OPTION_RST[OPT_EDGE_BIT];
            smp_prev_q <= OPTION_RST[OPT_EDGE_BIT];
        end else if (resync_q) begin
            smp_q <= psc_out;
            smp_prev_q <= psc_out;
        end else if (q2_en || q4_en) begin
            smp_q <= psc_out;
            smp_prev_q <= smp_q;
        end
    end

    // ==========================================================
    // Write hold-off: two instruction cycles after a count write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= HOLD_IDLE;
        end else if (wr_count) begin
            hold_q <= HOLD_TWO;
        end else if (q4_en) begin
            case (hold_q)
                HOLD_TWO: begin
                    hold_q <= HOLD_ONE;
                end
                HOLD_ONE: begin
                    hold_q <= HOLD_IDLE;
                end
                default: begin
                    hold_q <= HOLD_IDLE;
                end
            endcase
        end
    end

    // One increment per sampled rising edge, at most one per half cycle
    assign inc = (q2_en || q4_en) && smp_q && !smp_prev_q && !resync_q
        && (hold_q == HOLD_IDLE);
    assign wrap = inc && (count_register_q == 8'hFF);

    // ==========================================================
    // Count register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_register_q <= COUNT_RST;
        end else if (wr_count) begin
            count_register_q <= hwdata[7:0];
        end else if (inc) begin
            count_register_q <= count_register_q + 8'h01;
        end
    end

    // ==========================================================
    // Option register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opt_q <= option_t'(OPTION_RST);
        end else if (wr_option) begin
            opt_q.src_sel <= hwdata[OPT_SRC_BIT];
            opt_q.edge_sel <= hwdata[OPT_EDGE_BIT];
            opt_q.bypass <= hwdata[OPT_BYP_BIT];
            opt_q.rate <= hwdata[OPT_RATE_LSB +: RATE_WIDTH];
        end
    end

    // ==========================================================
    // Overflow flag and enable
    // A wrap in the same cycle as a software clear keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag_q <= 1'b0;
        end else if (wrap) begin
            overflow_flag_q <= 1'b1;
        end else if (wr_intctl && !hwdata[INT_FLAG_BIT]) begin
            overflow_flag_q <= 1'b0;
        end else if (wr_status && hwdata[IRQ_OVF_BIT]) begin
            overflow_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_irq_enable_q <= 1'b0;
        end else if (wr_intctl) begin
            overflow_irq_enable_q <= hwdata[INT_EN_BIT];
        end else if (wr_mask) begin
            overflow_irq_enable_q <= hwdata[IRQ_OVF_BIT];
        end
    end

    // Level request; in sleep no wrap can happen, so it rises only on an enable write
    assign irq = overflow_flag_q && overflow_irq_enable_q;

    // ==========================================================
    // Gate source for the companion timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_pulse_q <= 1'b0;
        end else begin
            ovf_pulse_q <= wrap;
        end
    end

    assign overflow_gate = ovf_pulse_q;

endmodule
`default_nettype wire

// ---- shared/tmr8_pkg.sv ----
// Constants, register map and field layouts of the 8-bit timer/counter
package tmr8_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] COUNT_OFS = 8'h00;
    localparam logic [7:0] OPTION_OFS = 8'h04;
    localparam logic [7:0] INTCTL_OFS = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // ==========================================================
    // Field positions
    localparam int OPT_SRC_BIT = 5;
    localparam int OPT_EDGE_BIT = 4;
    localparam int OPT_BYP_BIT = 3;
    localparam int OPT_RATE_LSB = 0;
    localparam int INT_EN_BIT = 5;
    localparam int INT_FLAG_BIT = 2;
    localparam int IRQ_OVF_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [5:0] OPTION_RST = 6'h3F;

    // ==========================================================
    // Timing
    localparam logic [1:0] PHASES_PER_CYCLE_M1 = 2'h3;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [1:0] WRITE_HOLDOFF_CYCLES = 2'h2;
    localparam int PSC_WIDTH = 8;
    localparam int RATE_WIDTH = 3;

    // ==========================================================
    // Types
    typedef struct packed {
        logic src_sel;
        logic edge_sel;
        logic bypass;
        logic [RATE_WIDTH-1:0] rate;
    } option_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic valid;
    } bus_req_t;

    typedef enum logic [2:0] {
        HOLD_IDLE = 3'b001,
        HOLD_ONE = 3'b010,
        HOLD_TWO = 3'b100
    } holdoff_t;

endpackage

// ---- src/tmr8_prescaler.sv ----
// Timer prescaler: ripple-free binary divider with a selectable tap
`timescale 1ns/1ps
`default_nettype none
module tmr8_prescaler
    import tmr8_pkg::*;
#(
    parameter int WIDTH = PSC_WIDTH,
    parameter int SEL_WIDTH = RATE_WIDTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic clear,
    input wire logic step,
    input wire logic [SEL_WIDTH-1:0] rate,
    // Tap
    output logic tap
);

    logic [WIDTH-1:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (clear) begin
            cnt_q <= '0;
        end else if (step) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Bit n has a period of 2^(n+1) steps
    always_comb begin
        tap = cnt_q[rate];
    end

endmodule
`default_nettype wire

// ---- dv/tmr8_core_asserts.sv ----
// Port-level assertions for the 8-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tmr8_core_asserts
    import tmr8_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // System
    input wire logic sleep_mode,
    input wire logic irq,
    input wire logic overflow_gate
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic take = hsel && hready && htrans[1];

    // ==========================================================
    // Overflow and interrupt
    // Flag and gate pulse are both registered from the same wrap
    sequence s_gate_now;
        overflow_gate;
    endsequence
    sequence s_wr_taken;
        take && hwrite;
    endsequence

    a_gate_one_cycle: assert property (
        overflow_gate |=> !overflow_gate)
        else $error("gate pulse longer than one cycle");
    a_irq_rise_cause: assert property (
        $rose(irq) |-> $past(take && hwrite, 2) or s_gate_now)
        else $error("irq rose without write or wrap");
    a_irq_sw_only: assert property (
        $fell(irq) |-> $past(take && hwrite, 2))
        else $error("irq dropped without a write");
    a_sleep_no_wrap: assert property (
        sleep_mode && $past(sleep_mode) |-> !overflow_gate)
        else $error("wrap seen during sleep");
    a_sleep_irq_kept: assert property (
        $past(sleep_mode) && !$past(take && hwrite, 2) |-> $stable(irq))
        else $error("irq moved during sleep");

    // ==========================================================
    // Register slave
    a_no_wait: assert property (s_wr_taken |-> hreadyout)
        else $error("wait state inserted");
    a_resp_okay: assert property (take |=> !hresp)
        else $error("error response given");
    a_unmapped_zero: assert property (
        take && !hwrite && haddr > 32'h10 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_narrow: assert property (
        take && !hwrite && haddr == {24'h0, COUNT_OFS}
        |=> hrdata[31:8] == 24'h0)
        else $error("count read wider than 8 bits");
endmodule
bind tmr8_core tmr8_core_asserts chk_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_mode(sleep_mode), .irq(irq),
    .overflow_gate(overflow_gate));
`default_nettype wire

// ---- dv/pin_pulse_src.sv ----
// Pulse source that drives the external count pin in bursts
`timescale 1ns/1ps
`default_nettype none
module pin_pulse_src (
    // Clock
    input wire logic hclk,
    // Request
    input wire logic start,
    input wire logic [7:0] pulses,
    // Pin side
    output logic pin,
    output logic busy
);
    logic [7:0] left_q;
    logic [2:0] tick_q;
    initial begin
        pin = 1'b0;
        left_q = 8'h00;
        tick_q = 3'h0;
    end
    assign busy = left_q != 8'h00;
    // Eight hclk per level keeps both levels well past the sync window
    always @(posedge hclk) begin
        if (start && !busy) begin
            left_q <= pulses;
            tick_q <= 3'h0;
        end else if (busy) begin
            tick_q <= tick_q + 3'h1;
            if (tick_q == 3'h7) begin
                pin <= !pin;
                if (pin) begin
                    left_q <= left_q - 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmr8_pkg::*;
    logic hclk, hresetn, hsel, hwrite, sleep_mode, rd_phase, go;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, irq, overflow_gate, pin, busy;
    logic [7:0] pulses;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int n_mismatch, checks_done, cyc, s, k, e, n_gate;
    logic [31:0] rst_tab[6] = '{0, {26'h0, OPTION_RST}, 0, 0, 0, 0};
    logic [31:0] ext_opt[3] = '{32'h28, 32'h38, 32'h20};
    int ext_shift[3] = '{0, 0, 1};

    tmr8_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .external_count_input(pin), .sleep_mode(sleep_mode), .irq(irq),
        .overflow_gate(overflow_gate));
    pin_pulse_src src_u (.hclk(hclk), .start(go), .pulses(pulses),
        .pin(pin), .busy(busy));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ==========================================================
    // Checking and closing
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ($isunknown(seen) || seen < lo || seen > hi) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h..%0h seen %0h",
                what, lo, hi, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic tend(input string name);
        $display("test %s done", name);
    endtask
    always @(posedge hclk) begin
        cyc++;
        if (overflow_gate === 1'b1) n_gate++;
        if (cyc == 60000) begin
            n_mismatch++;
            test_done();
        end
    end
    // Read results are matched against the oldest note
    always @(posedge hclk) begin
        if (rd_phase && hreadyout === 1'b1) begin
            note = exp_q.pop_front();
            chk("hrdata", hrdata, note[63:32], note[31:0]);
        end
    end

    // ==========================================================
    // Bus master
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] lo,
            input logic [31:0] hi);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        if (!w) exp_q.push_back({lo, hi});
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 0, 0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo,
            input logic [31:0] hi);
        xfer(1'b0, a, 0, lo, hi);
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_phase = 1'b0;
        go = 1'b0;
        pulses = 8'h00;
        sleep_mode = 1'b0;
        void'($urandom(54));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), rst_tab[i], rst_tab[i]);
        end
        tend("reset");
        s = $urandom_range(8'hE0, 8'h00);
        wr(OPTION_OFS, 32'h08);
        wr(COUNT_OFS, s);
        repeat (38) @(posedge hclk);
        rd(COUNT_OFS, s + 7, s + 9);
        tend("timer");
        for (int n = 0; n < 8; n++) begin
            wr(OPTION_OFS, n);
            wr(COUNT_OFS, 32'h0);
            repeat ((64 << n) - 2) @(posedge hclk);
            rd(COUNT_OFS, 6, 9);
        end
        tend("rates");
        wr(OPTION_OFS, 32'h08);
        wr(COUNT_OFS, 32'hFE);
        repeat (30) @(posedge hclk);
        rd(INTCTL_OFS, 32'h04, 32'h04);
        chk("irq", irq, 0, 0);
        wr(IRQ_MASK_OFS, 32'h1);
        repeat (40) @(posedge hclk);
        chk("irq", irq, 1, 1);
        rd(INTCTL_OFS, 32'h24, 32'h24);
        wr(INTCTL_OFS, 32'h20);
        rd(INTCTL_OFS, 32'h20, 32'h20);
        chk("irq", irq, 0, 0);
        wr(INTCTL_OFS, 32'h24);
        rd(IRQ_STATUS_OFS, 0, 0);
        chk("gate", n_gate, 1, 1);
        tend("overflow");
        sleep_mode <= 1'b1;
        wr(COUNT_OFS, 32'hFF);
        repeat (200) @(posedge hclk);
        rd(COUNT_OFS, 32'hFF, 32'hFF);
        rd(IRQ_STATUS_OFS, 0, 0);
        chk("gate", n_gate, 1, 1);
        sleep_mode <= 1'b0;
        repeat (30) @(posedge hclk);
        rd(IRQ_STATUS_OFS, 1, 1);
        chk("irq", irq, 1, 1);
        wr(IRQ_STATUS_OFS, 32'h1);
        rd(IRQ_STATUS_OFS, 0, 0);
        chk("gate", n_gate, 2, 2);
        tend("sleep");
        for (int i = 0; i < 3; i++) begin
            k = 2 * $urandom_range(10, 1);
            wr(OPTION_OFS, ext_opt[i]);
            wr(COUNT_OFS, 32'h0);
            repeat (10) @(posedge hclk);
            pulses <= 8'(k);
            go <= 1'b1;
            @(posedge hclk);
            go <= 1'b0;
            @(posedge hclk);
            for (int t = 0; t < 800 && busy !== 1'b0; t++) @(posedge hclk);
            repeat (20) @(posedge hclk);
            e = k >> ext_shift[i];
            rd(COUNT_OFS, e, e);
        end
        wr(OPTION_OFS, 32'h30);
        repeat (10) @(posedge hclk);
        rd(COUNT_OFS, e, e);
        tend("pin");
        test_done();
    end
endmodule
`default_nettype wire
